// [usb_port_status.sv]
/*
  Interrupt status, clear, endpoint reset and endpoint flag registers of a
  full-speed device port with six endpoints, behind a classic Wishbone slave.
  Assumes the packet engine gives one-cycle event pulses on clk_i, and that
  line activity, host resume, bus reset and external resume are async pins.
*/
// The register offsets and the Wishbone register port were left to the implementer.
`default_nettype none

module usb_port_status #(
  parameter int IDLE_CYCLES = usb_port_pkg::IDLE_CYCLES,
  parameter int WAKE_CYCLES = usb_port_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Asynchronous bus pins
  input wire logic line_active_i,
  input wire logic host_resume_i,
  input wire logic bus_reset_i,
  input wire logic ext_resume_i,
  // Packet engine events
  input wire logic frame_start_i,
  input wire logic [5:0] ev_setup_i,
  input wire logic [5:0] ev_bank0_i,
  input wire logic [5:0] ev_bank1_i,
  input wire logic [5:0] ev_tx_ack_i,
  input wire logic [5:0] ev_stall_i,
  input wire logic [10:0] rx_count_i,
  // Port state
  output logic irq_o,
  output logic suspended_o,
  output logic resume_drive_o,
  output logic [5:0] fifo_reset_o,
  output logic [5:0] data_toggle_o,
  output logic [5:0] out_accept_o,
  output logic [5:0] tx_ready_o,
  output logic [5:0] force_stall_o
);

  typedef enum logic [2:0] {
    ST_AWAKE = 3'b001,
    ST_SUSPENDED = 3'b010,
    ST_WAKING = 3'b100
  } power_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins and edges

  logic [3:0] level;
  logic [3:0] level_d_ff;
  logic host_resume_rise;
  logic bus_reset_fall;
  logic ext_resume_rise;
  logic line_idle;

  pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({ext_resume_i, bus_reset_i, host_resume_i, line_active_i}),
    .level_o(level)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_d_ff <= 4'h0;
    end else begin
      level_d_ff <= level;
    end
  end

  assign line_idle = ~level[0];
  assign host_resume_rise = level[1] & ~level_d_ff[1];
  assign bus_reset_fall = ~level[2] & level_d_ff[2];
  assign ext_resume_rise = level[3] & ~level_d_ff[3];

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode

  logic req;
  logic wr_req;
  logic csr_hit;
  logic [2:0] csr_idx;
  logic [7:0] csr_ofs;
  logic [31:0] nxt_rdata;
  logic [31:0] wmask;
  logic [31:0] wval;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_req = req & wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wval = wb_dat_i & wmask;
  assign csr_ofs = wb_adr_i - usb_port_pkg::OFS_CSR_BASE;
  assign csr_idx = csr_ofs[4:2];
  assign csr_hit = (wb_adr_i >= usb_port_pkg::OFS_CSR_BASE)
                   && (wb_adr_i <= usb_port_pkg::OFS_CSR_LAST) && (wb_adr_i[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint flag block

  ep_flags_if epb ();
  logic [5:0] nxt_csr_wr;

  always_comb begin
    nxt_csr_wr = 6'h00;
    if (wr_req && csr_hit && wb_sel_i[0]) begin
      nxt_csr_wr[csr_idx] = 1'b1;
    end
  end

  assign epb.csr_wr = nxt_csr_wr;
  assign epb.wdata = wb_dat_i;
  assign epb.fifo_reset = fifo_reset_o;
  assign epb.ev_setup = ev_setup_i;
  assign epb.ev_bank0 = ev_bank0_i;
  assign epb.ev_bank1 = ev_bank1_i;
  assign epb.ev_tx_ack = ev_tx_ack_i;
  assign epb.ev_stall = ev_stall_i;
  assign epb.rx_count = rx_count_i;

  ep_flags u_ep (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(epb)
  );

  assign data_toggle_o = epb.toggle;
  assign out_accept_o = epb.out_accept;
  assign tx_ready_o = epb.tx_ready;
  assign force_stall_o = epb.force_stall;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [13:0] mask_ff;
  logic remote_wake_enable_ff;
  logic clear_wr;
  logic [13:0] clr;

  assign clear_wr = wr_req && (wb_adr_i == usb_port_pkg::OFS_CLEAR);
  assign clr = clear_wr ? wval[13:0] : 14'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= usb_port_pkg::MASK_RESET;
      remote_wake_enable_ff <= 1'b0;
      fifo_reset_o <= 6'h00;
    end else if (wr_req) begin
      if (wb_adr_i == usb_port_pkg::OFS_MASK) begin
        mask_ff <= wval[13:0] & usb_port_pkg::STATUS_USED;
      end
      if (wb_adr_i == usb_port_pkg::OFS_CONTROL && wb_sel_i[0]) begin
        remote_wake_enable_ff <= wb_dat_i[usb_port_pkg::BIT_REMOTE_WAKE];
      end
      if (wb_adr_i == usb_port_pkg::OFS_FIFO_RESET && wb_sel_i[0]) begin
        fifo_reset_o <= wb_dat_i[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state: idle timer, suspend and remote wake drive

  power_state_t pstate_ff;
  logic [31:0] idle_cnt_ff;
  logic [31:0] wake_cnt_ff;
  logic suspend_event;
  logic ext_resume_event;
  logic wake_start;

  assign suspend_event = (pstate_ff == ST_AWAKE) && line_idle
                         && (idle_cnt_ff == 32'(IDLE_CYCLES - 1));
  assign ext_resume_event = (pstate_ff == ST_SUSPENDED) && ext_resume_rise;
  assign wake_start = ext_resume_event && remote_wake_enable_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i || !line_idle || pstate_ff != ST_AWAKE) begin
      idle_cnt_ff <= 32'h0000_0000;
    end else if (!suspend_event) begin
      idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pstate_ff <= ST_AWAKE;
      wake_cnt_ff <= 32'h0000_0000;
    end else begin
      case (pstate_ff)
        ST_AWAKE: begin
          if (suspend_event) begin
            pstate_ff <= ST_SUSPENDED;
          end
        end
        ST_SUSPENDED: begin
          if (wake_start) begin
            pstate_ff <= ST_WAKING;
            wake_cnt_ff <= 32'h0000_0000;
          end else if (!line_idle || host_resume_rise || level[2]) begin
            pstate_ff <= ST_AWAKE;
          end
        end
        ST_WAKING: begin
          if (wake_cnt_ff == 32'(WAKE_CYCLES - 1)) begin
            pstate_ff <= ST_AWAKE;
          end else begin
            wake_cnt_ff <= wake_cnt_ff + 32'h0000_0001;
          end
        end
        default: begin
          pstate_ff <= ST_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      suspended_o <= 1'b0;
      resume_drive_o <= 1'b0;
    end else begin
      suspended_o <= (pstate_ff == ST_SUSPENDED) || suspend_event;
      resume_drive_o <= wake_start || ((pstate_ff == ST_WAKING)
                        && (wake_cnt_ff != 32'(WAKE_CYCLES - 1)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky bus status bits: a new event wins over a clear

  logic susp_ff, rsm_ff, ext_ff, sof_ff, busres_ff, wake_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      susp_ff <= 1'b0;
      rsm_ff <= 1'b0;
      ext_ff <= 1'b0;
      sof_ff <= 1'b0;
      busres_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      susp_ff <= suspend_event | (susp_ff & ~clr[usb_port_pkg::BIT_SUSPEND]);
      rsm_ff <= host_resume_rise | (rsm_ff & ~clr[usb_port_pkg::BIT_RESUME]);
      ext_ff <= ext_resume_event | (ext_ff & ~clr[usb_port_pkg::BIT_EXT_RESUME]);
      sof_ff <= frame_start_i | (sof_ff & ~clr[usb_port_pkg::BIT_FRAME_START]);
      busres_ff <= bus_reset_fall
                   | (busres_ff & ~clr[usb_port_pkg::BIT_BUS_RESET_DONE]);
      wake_ff <= host_resume_rise | bus_reset_fall
                 | (wake_ff & ~clr[usb_port_pkg::BIT_WAKEUP]);
    end
  end

  logic [13:0] status;
  assign status = {wake_ff, busres_ff, sof_ff, ext_ff, rsm_ff, susp_ff,
                   2'h0, epb.ep_pending};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone read data and acknowledge

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (csr_hit) begin
      nxt_rdata = epb.csr_rd[csr_idx];
    end else begin
      case (wb_adr_i)
        usb_port_pkg::OFS_MASK: nxt_rdata = {18'h00000, mask_ff};
        usb_port_pkg::OFS_STATUS: nxt_rdata = {18'h00000, status};
        usb_port_pkg::OFS_FIFO_RESET: nxt_rdata = {26'h0000000, fifo_reset_o};
        usb_port_pkg::OFS_CONTROL: nxt_rdata = {31'h00000000, remote_wake_enable_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? nxt_rdata : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// [usb_port_pkg.sv]
/*
  Constants shared by the device port status logic: register offsets,
  field positions, reset values and timing counts.
  Assumes a 50 MHz peripheral clock and a classic Wishbone register bus.
*/
// Overview of operation
// - Endpoint status bit is OR of its flags
// - 3ms bus idle sets suspend bit, suspends
// - Resume signalling on port sets resume bit
// - External resume edge while suspended sets bit
// - Remote wake enabled: external resume drives bus
// - Each frame start token sets its bit
// - Bus reset finishing sets its done bit
// - Host resume or bus reset sets wakeup bit
// - Clear register: one clears, zero ignored
// - Endpoint reset holds byte count at zero
// - Endpoint reset returns data toggle to DATA0
// - Endpoint reset leaves event flags untouched
// - Host ack sets transmit complete; zero clears
// - Bank 0 packet sets flag; zero releases
// - Setup packet sets flag; zero acknowledges
// - Status bit zero idle, one once raised
// - Received byte count is eleven bits
// - No data OUT on control while setup set
// - Stall ack or iso CRC error; zero clears
`default_nettype none

package usb_port_pkg;

  localparam int NUM_EP = 6;
  localparam int CNT_W = 11;

  // Register offsets
  localparam logic [7:0] OFS_MASK = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLEAR = 8'h08;
  localparam logic [7:0] OFS_FIFO_RESET = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_CSR_BASE = 8'h20;
  localparam logic [7:0] OFS_CSR_LAST = 8'h34;

  // Status, clear and mask bit positions; control register bit
  localparam int BIT_SUSPEND = 8;
  localparam int BIT_RESUME = 9;
  localparam int BIT_EXT_RESUME = 10;
  localparam int BIT_FRAME_START = 11;
  localparam int BIT_BUS_RESET_DONE = 12;
  localparam int BIT_WAKEUP = 13;
  localparam int BIT_REMOTE_WAKE = 0;

  // Endpoint control/status fields
  localparam int CSR_TX_COMPLETE = 0;
  localparam int CSR_BANK0 = 1;
  localparam int CSR_SETUP = 2;
  localparam int CSR_STALL_ACK = 3;
  localparam int CSR_TX_READY = 4;
  localparam int CSR_FORCE_STALL = 5;
  localparam int CSR_BANK1 = 6;
  localparam int CSR_DIR = 7;
  localparam int CSR_KIND_LO = 8;
  localparam int CSR_TOGGLE = 11;
  localparam int CSR_ENABLE = 15;
  localparam int CSR_COUNT_LO = 16;
  localparam logic [2:0] KIND_CONTROL = 3'h0;

  // Mask reset value and used status bits
  localparam logic [13:0] MASK_RESET = 14'h0200;
  localparam logic [13:0] STATUS_USED = 14'h3f3f;

  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int IDLE_TIME_US = 3000;
  localparam int IDLE_CYCLES = (CLK_HZ / 1_000_000) * IDLE_TIME_US;
  localparam int WAKE_DRIVE_US = 2000;
  localparam int WAKE_CYCLES = (CLK_HZ / 1_000_000) * WAKE_DRIVE_US;

endpackage

`default_nettype wire

// [ep_flags_if.sv]
/*
  Bundle between the status block and the per-endpoint flag block.
  Assumes both ends share one clock.
*/
`default_nettype none

interface ep_flags_if;
  logic [5:0] csr_wr;
  logic [31:0] wdata;
  logic [5:0] fifo_reset;
  logic [5:0] ev_setup;
  logic [5:0] ev_bank0;
  logic [5:0] ev_bank1;
  logic [5:0] ev_tx_ack;
  logic [5:0] ev_stall;
  logic [10:0] rx_count;
  logic [5:0][31:0] csr_rd;
  logic [5:0] ep_pending;
  logic [5:0] toggle;
  logic [5:0] out_accept;
  logic [5:0] tx_ready;
  logic [5:0] force_stall;

  modport ctl (
    output csr_wr, wdata, fifo_reset, ev_setup, ev_bank0, ev_bank1, ev_tx_ack, ev_stall,
    output rx_count,
    input csr_rd, ep_pending, toggle, out_accept, tx_ready, force_stall
  );
  modport ep (
    input csr_wr, wdata, fifo_reset, ev_setup, ev_bank0, ev_bank1, ev_tx_ack, ev_stall,
    input rx_count,
    output csr_rd, ep_pending, toggle, out_accept, tx_ready, force_stall
  );
endinterface

`default_nettype wire

// [pin_sync.sv]
/*
  Two-stage synchroniser for four asynchronous pins.
  Assumes the inputs are levels from outside the clock domain.
*/
`default_nettype none

module pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and synchronised levels
  input wire logic [3:0] pin_i,
  output logic [3:0] level_o
);

  logic [3:0] meta_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 4'h0;
      level_o <= 4'h0;
    end else begin
      meta_ff <= pin_i;
      level_o <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// [ep_flags.sv]
/*
  Per-endpoint control/status flags, byte count and data toggle.
  Assumes packet events are one-cycle pulses on the same clock.
*/
`default_nettype none

module ep_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bundle from the status block
  ep_flags_if.ep bus
);

  genvar g;
  generate
    for (g = 0; g < usb_port_pkg::NUM_EP; g++) begin : g_ep
      logic txc_ff, bk0_ff, setup_ff, stall_ff, rdy_ff, fst_ff, bk1_ff, dir_ff, tgl_ff, en_ff;
      logic acc_ff;
      logic [2:0] kind_ff;
      logic [10:0] cnt_ff;
      logic wr;
      logic [31:0] wd;

      assign wr = bus.csr_wr[g];
      assign wd = bus.wdata;

      // Event flags: set wins over a write of zero
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          txc_ff <= 1'b0;
          bk0_ff <= 1'b0;
          setup_ff <= 1'b0;
          stall_ff <= 1'b0;
          bk1_ff <= 1'b0;
        end else begin
          txc_ff <= bus.ev_tx_ack[g] | (txc_ff & ~(wr & ~wd[usb_port_pkg::CSR_TX_COMPLETE]));
          bk0_ff <= bus.ev_bank0[g] | (bk0_ff & ~(wr & ~wd[usb_port_pkg::CSR_BANK0]));
          setup_ff <= bus.ev_setup[g] | (setup_ff & ~(wr & ~wd[usb_port_pkg::CSR_SETUP]));
          stall_ff <= bus.ev_stall[g] | (stall_ff & ~(wr & ~wd[usb_port_pkg::CSR_STALL_ACK]));
          bk1_ff <= bus.ev_bank1[g] | (bk1_ff & ~(wr & ~wd[usb_port_pkg::CSR_BANK1]));
        end
      end

      // Firmware settings; transmit ready cleared by the host acknowledge
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rdy_ff <= 1'b0;
          fst_ff <= 1'b0;
          dir_ff <= 1'b0;
          kind_ff <= usb_port_pkg::KIND_CONTROL;
          en_ff <= 1'b0;
        end else begin
          if (bus.ev_tx_ack[g]) begin
            rdy_ff <= 1'b0;
          end else if (wr && wd[usb_port_pkg::CSR_TX_READY]) begin
            rdy_ff <= 1'b1;
          end
          if (wr) begin
            fst_ff <= wd[usb_port_pkg::CSR_FORCE_STALL];
            dir_ff <= wd[usb_port_pkg::CSR_DIR];
            kind_ff <= wd[usb_port_pkg::CSR_KIND_LO +: 3];
            en_ff <= wd[usb_port_pkg::CSR_ENABLE];
          end
        end
      end

      // Byte count and toggle; endpoint reset touches only these
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_ff <= 11'h000;
          tgl_ff <= 1'b0;
        end else if (bus.fifo_reset[g]) begin
          cnt_ff <= 11'h000;
          tgl_ff <= 1'b0;
        end else begin
          if (bus.ev_bank0[g] || bus.ev_bank1[g] || bus.ev_setup[g]) begin
            cnt_ff <= bus.rx_count;
          end
          if (bus.ev_tx_ack[g] || bus.ev_bank0[g] || bus.ev_bank1[g]) begin
            tgl_ff <= ~tgl_ff;
          end
        end
      end

      // Data OUT refused on a control endpoint while setup is pending
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          acc_ff <= 1'b1;
        end else begin
          acc_ff <= ~(nxt_setup(setup_ff, wr, wd, bus.ev_setup[g])
                      && (kind_ff == usb_port_pkg::KIND_CONTROL));
        end
      end

      assign bus.ep_pending[g] = txc_ff | bk0_ff | setup_ff | stall_ff | bk1_ff;
      assign bus.toggle[g] = tgl_ff;
      assign bus.out_accept[g] = acc_ff;
      assign bus.tx_ready[g] = rdy_ff;
      assign bus.force_stall[g] = fst_ff;
      assign bus.csr_rd[g] = {5'h00, cnt_ff, en_ff, 3'h0, tgl_ff, kind_ff,
                              dir_ff, bk1_ff, fst_ff, rdy_ff, stall_ff, setup_ff, bk0_ff, txc_ff};
    end
  endgenerate

  function automatic logic nxt_setup(input logic cur, input logic wr, input logic [31:0] wd,
                                     input logic ev);
    nxt_setup = ev | (cur & ~(wr & ~wd[usb_port_pkg::CSR_SETUP]));
  endfunction

endmodule

`default_nettype wire

// [usb_port_status_sva.sv]
/*
  Pin-level assertions for the device port status block.
  Assumes it is bound to usb_port_status with the same counts.
*/
`default_nettype none

module usb_port_status_sva #(
  parameter int IDLE_CYCLES = 50,
  parameter int WAKE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched pins
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic line_active_i,
  input wire logic ext_resume_i,
  input wire logic [5:0] ev_setup_i,
  input wire logic [5:0] ev_tx_ack_i,
  input wire logic suspended_o,
  input wire logic resume_drive_o,
  input wire logic [5:0] fifo_reset_o,
  input wire logic [5:0] data_toggle_o,
  input wire logic [5:0] out_accept_o,
  input wire logic [5:0] tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int idle_cnt;
  int wake_cnt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Idle and drive length counters
  always_ff @(posedge clk_i) begin
    if (rst_i || line_active_i) idle_cnt <= 0;
    else idle_cnt <= idle_cnt + 1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !resume_drive_o) wake_cnt <= 0;
    else wake_cnt <= wake_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  chk_toggle_held: assert property (
    (fifo_reset_o & $past(fifo_reset_o) & data_toggle_o) == 6'h00)
    else $error("toggle not zero under endpoint reset");
  chk_setup_refuse: assert property (ev_setup_i[0] |-> ##[1:2] !out_accept_o[0])
    else $error("data out accepted with setup pending");
  chk_suspend_time: assert property ($rose(suspended_o) |->
    idle_cnt >= IDLE_CYCLES && idle_cnt <= IDLE_CYCLES + 6)
    else $error("suspend at wrong idle time");
  chk_wake_length: assert property ($fell(resume_drive_o) |-> wake_cnt == WAKE_CYCLES)
    else $error("resume drive length wrong");
  chk_wake_cause: assert property ($rose(resume_drive_o) |->
    ext_resume_i && $past(suspended_o))
    else $error("resume drive without request");
  chk_ready_drop: assert property (ev_tx_ack_i[2] |-> ##[1:2] !tx_ready_o[2])
    else $error("tx ready kept after ack");
  chk_reset_values: assert property ($fell(rst_i) |-> out_accept_o == 6'h3f
    && fifo_reset_o == 6'h00 && !suspended_o && !resume_drive_o)
    else $error("outputs wrong after reset");

  cov_suspend: cover property ($rose(suspended_o));
  cov_wake: cover property ($rose(resume_drive_o));
  cov_read: cover property (wb_ack_o && wb_dat_o != 32'h00000000);
endmodule

`default_nettype wire

// [usb_host_model.sv]
/*
  Behavioural host and packet engine side of the port.
  Assumes the caller invokes its tasks one at a time.
*/
`default_nettype none

module usb_host_model (
  // Clock
  input wire logic clk_i,
  // Bus state
  output logic line_active_o,
  output logic host_resume_o,
  output logic bus_reset_o,
  output logic frame_start_o,
  // Events: setup, bank0, bank1, tx ack, stall
  output logic [4:0][5:0] ev_o,
  output logic [10:0] rx_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    line_active_o = 1'b1;
    host_resume_o = 1'b0;
    bus_reset_o = 1'b0;
    frame_start_o = 1'b0;
    ev_o = '0;
    rx_count_o = 11'h000;
  end

  task automatic line(input logic v);
    @(posedge clk_i);
    line_active_o <= v;
  endtask

  // Resume (0) or bus reset (1) held n cycles
  task automatic pin(input int which, input int n);
    @(posedge clk_i);
    if (which == 0) host_resume_o <= 1'b1;
    else bus_reset_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    host_resume_o <= 1'b0;
    bus_reset_o <= 1'b0;
  endtask

  task automatic frame();
    @(posedge clk_i);
    frame_start_o <= 1'b1;
    @(posedge clk_i);
    frame_start_o <= 1'b0;
  endtask

  // Count is valid with the pulse only, inverted afterwards
  task automatic pulse_ev(input int kind, input int ep, input logic [10:0] cnt);
    @(posedge clk_i);
    ev_o[kind][ep] <= 1'b1;
    rx_count_o <= cnt;
    @(posedge clk_i);
    ev_o[kind][ep] <= 1'b0;
    rx_count_o <= ~cnt;
  endtask
endmodule

`default_nettype wire

// [tb_usb_port_status.sv]
/*
  Register-level testbench of the device port status block.
  Assumes the host model drives the bus pins and events.
*/
`default_nettype none

module tb_usb_port_status;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_N = 50;
  localparam int WAKE_N = 20;
  localparam logic [7:0] MK = usb_port_pkg::OFS_MASK;
  localparam logic [7:0] ST = usb_port_pkg::OFS_STATUS;
  localparam logic [7:0] CL = usb_port_pkg::OFS_CLEAR;
  localparam logic [7:0] FR = usb_port_pkg::OFS_FIFO_RESET;
  localparam logic [7:0] CT = usb_port_pkg::OFS_CONTROL;
  localparam logic [7:0] CS = usb_port_pkg::OFS_CSR_BASE;
  logic clk_i, rst_i, req, we, ext_res, ack, irq, susp, drv;
  logic line_act, h_res, b_res, sof;
  logic [7:0] adr;
  logic [31:0] dat_w, dat_r, rd;
  logic [4:0][5:0] ev;
  logic [10:0] cnt;
  logic [5:0] frst, tgl, acc, txr, fst;
  int n_fail, n_checks, k;
  int fb[5] = '{2, 1, 6, 0, 3};

  usb_host_model host (.clk_i(clk_i), .line_active_o(line_act), .host_resume_o(h_res),
    .bus_reset_o(b_res), .frame_start_o(sof), .ev_o(ev), .rx_count_o(cnt));

  usb_port_status #(.IDLE_CYCLES(IDLE_N), .WAKE_CYCLES(WAKE_N)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .line_active_i(line_act), .host_resume_i(h_res), .bus_reset_i(b_res),
    .ext_resume_i(ext_res), .frame_start_i(sof), .ev_setup_i(ev[0]), .ev_bank0_i(ev[1]),
    .ev_bank1_i(ev[2]), .ev_tx_ack_i(ev[3]), .ev_stall_i(ev[4]), .rx_count_i(cnt),
    .irq_o(irq), .suspended_o(susp), .resume_drive_o(drv), .fifo_reset_o(frst),
    .data_toggle_o(tgl), .out_accept_o(acc), .tx_ready_o(txr), .force_stall_o(fst));

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    rd = dat_r;
    req <= 1'b0;
    we <= 1'b0;
    if (i == 20) begin
      n_fail++;
      $display("MISMATCH %0t no ack", $time);
      results();
    end
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_w = 32'h0;
    ext_res = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(MK, 32'hffffffff, 32'h00000200);
    rchk(ST, 32'hffffffff, 32'h00000000);
    bus(1'b1, 8'h40, 32'hffffffff);
    rchk(8'h40, 32'hffffffff, 32'h00000000);
    bus(1'b1, CL, 32'h00003f00);
    $display("test reset done");
    host.frame();
    rchk(ST, 32'h800, 32'h800);
    bus(1'b1, CL, 32'h0);
    rchk(ST, 32'h800, 32'h800);
    bus(1'b1, CL, 32'h800);
    rchk(ST, 32'h800, 32'h0);
    $display("test frame done");
    for (k = 0; k < 5; k++) begin
      host.pulse_ev(k, 3, 11'h005);
      rchk(CS + 8'h0c, 32'h1 << fb[k], 32'h1 << fb[k]);
      rchk(ST, 32'h8, 32'h8);
      bus(1'b1, CS + 8'h0c, 32'h4f);
      rchk(CS + 8'h0c, 32'h1 << fb[k], 32'h1 << fb[k]);
      bus(1'b1, CS + 8'h0c, 32'h0);
      rchk(ST, 32'h8, 32'h0);
    end
    $display("test flags done");
    host.pulse_ev(1, 1, 11'h7ff);
    rchk(CS + 8'h04, 32'h07ff0002, 32'h07ff0002);
    cmp(tgl[1], 1'b1);
    bus(1'b1, FR, 32'h2);
    cmp(frst, 6'h02);
    rchk(CS + 8'h04, 32'h07ff0802, 32'h00000002);
    cmp(tgl[1], 1'b0);
    rchk(FR, 32'h3f, 32'h2);
    bus(1'b1, FR, 32'h0);
    bus(1'b1, CS + 8'h04, 32'h0);
    $display("test endpoint reset done");
    host.pulse_ev(0, 0, 11'h008);
    rchk(CS, 32'h4, 32'h4);
    cmp(acc[0], 1'b0);
    bus(1'b1, CS, 32'h0);
    repeat (3) @(posedge clk_i);
    cmp(acc[0], 1'b1);
    bus(1'b1, CS + 8'h08, 32'h30);
    cmp(txr[2], 1'b1);
    cmp(fst[2], 1'b1);
    host.pulse_ev(3, 2, 11'h000);
    rchk(CS + 8'h08, 32'h11, 32'h01);
    bus(1'b1, CS + 8'h08, 32'h0);
    $display("test setup and transmit done");
    bus(1'b1, CT, 32'h1);
    host.line(1'b0);
    repeat (IDLE_N + 10) @(posedge clk_i);
    cmp(susp, 1'b1);
    rchk(ST, 32'h100, 32'h100);
    ext_res <= 1'b1;
    repeat (8) @(posedge clk_i);
    cmp(drv, 1'b1);
    rchk(ST, 32'h400, 32'h400);
    repeat (WAKE_N) @(posedge clk_i);
    cmp(drv, 1'b0);
    ext_res <= 1'b0;
    host.pin(0, 8);
    repeat (6) @(posedge clk_i);
    rchk(ST, 32'h2200, 32'h2200);
    cmp(irq, 1'b1);
    host.line(1'b1);
    bus(1'b1, CL, 32'h3f00);
    rchk(ST, 32'h3f00, 32'h0);
    cmp(irq, 1'b0);
    host.pin(1, 8);
    repeat (6) @(posedge clk_i);
    rchk(ST, 32'h3000, 32'h3000);
    $display("test suspend and wake done");
    results();
  end
endmodule

bind usb_port_status usb_port_status_sva #(.IDLE_CYCLES(IDLE_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)) sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .line_active_i(line_active_i), .ext_resume_i(ext_resume_i), .ev_setup_i(ev_setup_i),
  .ev_tx_ack_i(ev_tx_ack_i), .suspended_o(suspended_o), .resume_drive_o(resume_drive_o),
  .fifo_reset_o(fifo_reset_o), .data_toggle_o(data_toggle_o),
  .out_accept_o(out_accept_o), .tx_ready_o(tx_ready_o));

`default_nettype wire
